// [hw/bbc_consts.svh]
// constants for the buck-boost channel control register bank
// assumes a byte-wide register port from the serial management front end
//
// What this block does
// - ch3 enable code 0-3 picks sequencer slot, 4-5 forces off, 6-7 forces on.
// - discharge enable 1 with channel disabled switches discharge resistor on.
// - discharge enable 0 keeps discharge resistor off while channel disabled.
// - fast ramp select bit 5 picks 5 mV/us when 0, 10 mV/us when 1.
// - low latency select cuts code-change-to-ramp delay from 100 us to 10 us.
// - low latency select is ignored for channels whose rise select is 0.
// - rise select bits 0-3 give 2 mV/us when 0, else the fast ramp rate.
// - power mode follows bias low-power and internal-channel-disable bits.
// - valley current at eight steps sets fault flags of affected channels.
// - target code gives 0.5 V plus code times 25 mV, or 12.5 mV on fine step; above 0xc8 reserved on coarse step.
// - overload status shows present state; overload flags stay latched.
`ifndef BBC_CONSTS_SVH
`define BBC_CONSTS_SVH
// ***************
// register map
// ***************
`define BBC_CH3_CFG_ADDR   8'h0f
`define BBC_RAMP_CFG_ADDR  8'h10
`define BBC_CH3_CFG_RST    4'h0
`define BBC_RAMP_CFG_RST   6'h00
`define BBC_CH3_ADE_BIT    3
`define BBC_FAST_RATE_BIT  5
`define BBC_LOW_LAT_BIT    4
`define BBC_CH3_RISE_BIT   3
// ***************
// ramp rates, mV/us
// ***************
`define BBC_RATE_SLOW      4'h2
`define BBC_RATE_FAST_LO   4'h5
`define BBC_RATE_FAST_HI   4'ha
// ***************
// latencies
// ***************
`define BBC_CLK_MHZ        250
`define BBC_LAT_SLOW_US    100
`define BBC_LAT_FAST_US    10
`define BBC_LAT_CW         15
// ***************
// target voltage, units of 0.1 mV
// ***************
`define BBC_TV_BASE        17'h01388
`define BBC_TV_STEP_COARSE 17'h000fa
`define BBC_TV_STEP_FINE   17'h0007d
`define BBC_TV_MAX_CODE    8'hc8
`endif

// [hw/bbc_pkg.sv]
// types for the buck-boost channel control register bank
// field widths are written out here, not taken from bbc_consts.svh, and match those in it
`default_nettype none
package bbc_pkg;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } bbc_req_type;

   typedef enum logic [1:0] {
      BBC_PM_NORMAL   = 2'b00,
      BBC_PM_LOW      = 2'b01,
      BBC_PM_BIAS_NRM = 2'b11
   } bbc_pmode_type;

   typedef enum logic [1:0] {
      BBC_LAT_IDLE  = 2'b00,
      BBC_LAT_WAIT  = 2'b01,
      BBC_LAT_START = 2'b11
   } bbc_lat_type;

   typedef struct packed {
      logic [3:0]    ch3_cfg;
      logic [5:0]    ramp_cfg;
      logic [7:0]    rdata;
      logic          vmax_s1;
      logic          vmax_s2;
      logic [3:0]    status;
      logic [3:0]    flags;
      logic [7:0]    code_prev;
      bbc_lat_type   lat_state;
      logic [14:0]   lat_cnt;
   } bbc_state_type;
endpackage : bbc_pkg
`default_nettype wire

// [hw/bbc_channel_ctrl_regs.sv]
// channel 3 enable/discharge, shared ramp control, power mode and overload flags
// assumes register port and sequencer signals on ref_clk; valley comparator async
`include "bbc_consts.svh"
`default_nettype none
module bbc_channel_ctrl_regs #(
   parameter int LAT_SLOW_CYC = `BBC_LAT_SLOW_US * `BBC_CLK_MHZ,
   parameter int LAT_FAST_CYC = `BBC_LAT_FAST_US * `BBC_CLK_MHZ
) (
   // clock and reset
   input  wire logic                ref_clk,
   input  wire logic                reset_n,
   // register port
   input  wire bbc_pkg::bbc_req_type reg_req,
   output logic [7:0]               reg_rdata,
   // global bias bits
   input  wire logic                bias_low_power,
   input  wire logic                internal_channel_disable,
   output bbc_pkg::bbc_pmode_type   power_mode,
   // channel 3 enable
   input  wire logic                ch3_running,
   output logic                     ch3_slot_valid,
   output logic [1:0]               power_sequencer_slot,
   output logic                     ch3_force_on,
   output logic                     ch3_force_off,
   output logic                     ch3_discharge_on,
   // ramp control
   output logic [3:0][3:0]          rise_rate_mv_us,
   output logic [3:0]               low_latency_eff,
   input  wire logic [7:0]          target_voltage_code,
   input  wire logic                voltage_step_size,
   output logic [16:0]              ch3_target_dmv,
   output logic                     ch3_target_reserved,
   output logic                     ch3_ramp_start,
   // overload
   input  wire logic                valley_at_max,
   input  wire logic [3:0]          channel_serviced,
   input  wire logic [3:0]          flag_clear,
   output logic [3:0]               overload_status,
   output logic [3:0]               overload_flag
);
   // ***************
   // state
   // ***************
   bbc_pkg::bbc_state_type s_r;
   bbc_pkg::bbc_state_type s_nxt;
   logic                   ch3_wr;
   logic                   ramp_wr;
   logic                   code_chg;
   logic                   fast_rate;

   assign ch3_wr    = reg_req.wr && (reg_req.addr == `BBC_CH3_CFG_ADDR);
   assign ramp_wr   = reg_req.wr && (reg_req.addr == `BBC_RAMP_CFG_ADDR);
   assign code_chg  = (target_voltage_code != s_r.code_prev);
   assign fast_rate = s_r.ramp_cfg[`BBC_FAST_RATE_BIT];

   // ***************
   // next state
   // ***************
   always_comb begin
      s_nxt = s_r;
      // upper bits masked off so they never store
      if (ch3_wr) begin
         s_nxt.ch3_cfg = reg_req.wdata[3:0];
      end
      if (ramp_wr) begin
         s_nxt.ramp_cfg = reg_req.wdata[5:0];
      end
      if (reg_req.rd) begin
         case (reg_req.addr)
            `BBC_CH3_CFG_ADDR:  s_nxt.rdata = {4'h0, s_r.ch3_cfg};
            `BBC_RAMP_CFG_ADDR: s_nxt.rdata = {2'h0, s_r.ramp_cfg};
            default:            s_nxt.rdata = 8'h00;
         endcase
      end
      // comparator is analog, so two flops before use
      s_nxt.vmax_s1 = valley_at_max;
      s_nxt.vmax_s2 = s_r.vmax_s1;
      s_nxt.status  = {4{s_r.vmax_s2}} & channel_serviced;
      // set wins over a clear in the same cycle
      s_nxt.flags   = (s_r.flags & ~flag_clear) | s_r.status;
      // ramp start delay for channel 3
      s_nxt.code_prev = target_voltage_code;
      case (s_r.lat_state)
         bbc_pkg::BBC_LAT_IDLE: begin
            if (code_chg) begin
               s_nxt.lat_state = bbc_pkg::BBC_LAT_WAIT;
            end
         end
         bbc_pkg::BBC_LAT_WAIT: begin
            if (code_chg) begin
               s_nxt.lat_state = bbc_pkg::BBC_LAT_WAIT;
            end else if (s_r.lat_cnt == '0) begin
               s_nxt.lat_state = bbc_pkg::BBC_LAT_START;
            end else begin
               s_nxt.lat_cnt = s_r.lat_cnt - 15'h0001;
            end
         end
         bbc_pkg::BBC_LAT_START: begin
            s_nxt.lat_state = code_chg ? bbc_pkg::BBC_LAT_WAIT : bbc_pkg::BBC_LAT_IDLE;
         end
         default: begin
            s_nxt.lat_state = bbc_pkg::BBC_LAT_IDLE;
         end
      endcase
      // a new code always restarts the wait
      if (code_chg) begin
         s_nxt.lat_cnt = low_latency_eff[3] ? 15'(LAT_FAST_CYC - 1)
                                            : 15'(LAT_SLOW_CYC - 1);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         s_r.ch3_cfg   <= `BBC_CH3_CFG_RST;
         s_r.ramp_cfg  <= `BBC_RAMP_CFG_RST;
         s_r.rdata     <= 8'h00;
         s_r.vmax_s1   <= 1'b0;
         s_r.vmax_s2   <= 1'b0;
         s_r.status    <= 4'h0;
         s_r.flags     <= 4'h0;
         s_r.code_prev <= 8'h00;
         s_r.lat_state <= bbc_pkg::BBC_LAT_IDLE;
         s_r.lat_cnt   <= 15'h0000;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ***************
   // channel 3 enable and discharge
   // ***************
   assign ch3_slot_valid       = ~s_r.ch3_cfg[2];
   assign power_sequencer_slot = s_r.ch3_cfg[1:0];
   assign ch3_force_off        = (s_r.ch3_cfg[2:1] == 2'b10);
   assign ch3_force_on         = (s_r.ch3_cfg[2:1] == 2'b11);
   // resistor only while the regulator is not driving the output
   assign ch3_discharge_on = s_r.ch3_cfg[`BBC_CH3_ADE_BIT] & ~ch3_running;

   // ***************
   // per-channel ramp rate
   // ***************
   for (genvar i = 0; i < 4; i++) begin : g_ch
      always_comb begin
         if (!s_r.ramp_cfg[i]) begin
            rise_rate_mv_us[i] = `BBC_RATE_SLOW;
         end else if (fast_rate) begin
            rise_rate_mv_us[i] = `BBC_RATE_FAST_HI;
         end else begin
            rise_rate_mv_us[i] = `BBC_RATE_FAST_LO;
         end
      end
      assign low_latency_eff[i] = s_r.ramp_cfg[`BBC_LOW_LAT_BIT] & s_r.ramp_cfg[i];
   end

   assign ch3_ramp_start = (s_r.lat_state == bbc_pkg::BBC_LAT_START);

   // ***************
   // target voltage
   // ***************
   // fine step is 12.5 mV; reserved codes only exist on the coarse step
   assign ch3_target_dmv = `BBC_TV_BASE + 17'(target_voltage_code) *
                           (voltage_step_size ? `BBC_TV_STEP_FINE : `BBC_TV_STEP_COARSE);
   assign ch3_target_reserved = ~voltage_step_size &&
                                (target_voltage_code > `BBC_TV_MAX_CODE);

   // ***************
   // power mode and outputs
   // ***************
   always_comb begin
      if (!bias_low_power) begin
         power_mode = bbc_pkg::BBC_PM_NORMAL;
      end else if (!internal_channel_disable) begin
         power_mode = bbc_pkg::BBC_PM_LOW;
      end else begin
         power_mode = bbc_pkg::BBC_PM_BIAS_NRM;
      end
   end

   assign reg_rdata       = s_r.rdata;
   assign overload_status = s_r.status;
   assign overload_flag   = s_r.flags;

   // ***************
   // checks
   // ***************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   a_slot_force_on: assert property (
      ch3_wr && reg_req.wdata[2:1] == 2'b11 |=>
         ch3_force_on && !ch3_force_off && !ch3_slot_valid)
      else $error("ch3 code 6/7 did not force on");

   a_slot_pick: assert property (
      ch3_wr && !reg_req.wdata[2] |=>
         ch3_slot_valid && power_sequencer_slot == $past(reg_req.wdata[1:0]))
      else $error("ch3 slot code not applied");

   a_discharge_on: assert property (
      ch3_wr && reg_req.wdata[3] ##1 !ch3_running |-> ch3_discharge_on)
      else $error("discharge resistor not on");

   a_discharge_off: assert property (
      !s_r.ch3_cfg[3] || ch3_running |-> !ch3_discharge_on)
      else $error("discharge resistor on unexpectedly");

   a_fast_rate: assert property (
      ramp_wr && reg_req.wdata[5] && reg_req.wdata[3] |=>
         rise_rate_mv_us[3] == `BBC_RATE_FAST_HI)
      else $error("fast ramp rate wrong");

   a_slow_rise: assert property (
      ramp_wr && !reg_req.wdata[0] |=> rise_rate_mv_us[0] == `BBC_RATE_SLOW)
      else $error("slow rise rate wrong");

   a_fast_load: assert property (
      code_chg && s_r.ramp_cfg[4] && s_r.ramp_cfg[3] |=>
         s_r.lat_cnt == 15'(LAT_FAST_CYC - 1) && !ch3_ramp_start)
      else $error("low latency delay not loaded");

   a_lat_ignored: assert property (
      code_chg && !s_r.ramp_cfg[3] |=> s_r.lat_cnt == 15'(LAT_SLOW_CYC - 1))
      else $error("low latency not ignored");

   a_ramp_pulse: assert property (
      ch3_ramp_start |-> $past(s_r.lat_cnt) == '0 ##1 !ch3_ramp_start || $past(code_chg))
      else $error("ramp start not one cycle after count end");

   a_power_mode: assert property (
      (!bias_low_power |-> power_mode == bbc_pkg::BBC_PM_NORMAL) and
      (bias_low_power && internal_channel_disable |-> power_mode == bbc_pkg::BBC_PM_BIAS_NRM))
      else $error("power mode decode wrong");

   a_flag_set: assert property (
      s_r.vmax_s2 && channel_serviced != 4'h0 |=>
         ##1 (overload_flag & $past(channel_serviced, 2)) == $past(channel_serviced, 2))
      else $error("overload flag not set");

   a_flag_latch: assert property (
      overload_flag[0] && !flag_clear[0] |=> overload_flag[0])
      else $error("overload flag dropped without clear");

   a_reserved_zero: assert property (
      reg_req.rd && reg_req.addr == `BBC_CH3_CFG_ADDR |=> reg_rdata[7:4] == 4'h0)
      else $error("reserved bits read nonzero");

   a_target_top: assert property (
      !voltage_step_size && target_voltage_code == `BBC_TV_MAX_CODE |->
         ch3_target_dmv == 17'h0d6d8 && !ch3_target_reserved)
      else $error("top target voltage wrong");
endmodule : bbc_channel_ctrl_regs
`default_nettype wire

// [verification/bbc_host_model.sv]
// host-side register master for the channel control bank
// assumes the byte port is sampled on rising ref_clk; drives at the falling edge
`default_nettype none
module bbc_host_model (
   // clock
   input  wire logic            ref_clk,
   // register port
   output bbc_pkg::bbc_req_type reg_req,
   input  wire logic [7:0]      reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial reg_req = '0;
   // idle address and data are inverted so a stale byte never passes as valid
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_req = {w, ~w, a, d};
      @(negedge ref_clk);
      reg_req = {2'b00, ~a, ~d};
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      xfer(1'b0, a, 8'h00);
      d = reg_rdata;
   endtask : rd
endmodule : bbc_host_model
`default_nettype wire

// [verification/tb.sv]
// self-checking bench for the channel control register bank
// assumes short ramp latencies (12 and 40 cycles) set through parameters
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0, reset_n = 1'b0, blp, icd, run, step, valley;
   logic [7:0] code, rd;
   logic [3:0] serv, fclr, lle, ost, ofl;
   logic [3:0][3:0] rate;
   logic sv, fon, foff, dis, rsv, rst_pulse;
   logic [1:0] slot;
   logic [16:0] dmv;
   bbc_pkg::bbc_req_type req;
   bbc_pkg::bbc_pmode_type pm;
   int n_fail = 0, num_checks = 0, cyc = 0, i, c;
   localparam int LAT_F = 12;
   localparam int LAT_S = 40;
   wire logic [7:0] rd_w;
   always #2 ref_clk = ~ref_clk;
   bbc_channel_ctrl_regs #(.LAT_SLOW_CYC(LAT_S), .LAT_FAST_CYC(LAT_F)) DUT (
      .ref_clk(ref_clk), .reset_n(reset_n), .reg_req(req), .reg_rdata(rd_w),
      .bias_low_power(blp), .internal_channel_disable(icd), .power_mode(pm),
      .ch3_running(run), .ch3_slot_valid(sv), .power_sequencer_slot(slot),
      .ch3_force_on(fon), .ch3_force_off(foff), .ch3_discharge_on(dis),
      .rise_rate_mv_us(rate), .low_latency_eff(lle), .target_voltage_code(code),
      .voltage_step_size(step), .ch3_target_dmv(dmv), .ch3_target_reserved(rsv),
      .ch3_ramp_start(rst_pulse), .valley_at_max(valley), .channel_serviced(serv),
      .flag_clear(fclr), .overload_status(ost), .overload_flag(ofl));
   bbc_host_model H (.ref_clk(ref_clk), .reg_req(req), .reg_rdata(rd_w));
   task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish
   // only a pulse check can see the ramp start, so count edges after the change
   task automatic lat(input logic [7:0] cfg, input logic [7:0] cd, input int n_exp);
      int n;
      H.wr(8'h10, cfg);
      @(negedge ref_clk) code = cd;
      @(posedge ref_clk);
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
         #1;
      end while (!rst_pulse && n < 100);
      chk("ramp_lat", n_exp[16:0], n[16:0]);
      chk("dmv", 17'h01388 + cd * (step ? 17'h0007d : 17'h000fa), dmv);
      chk("rsv", {16'h0, !step && cd > 8'hc8}, {16'h0, rsv});
   endtask : lat
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   // ****************
   // test sequence
   // ****************
   initial begin
      {blp, icd, run, step, valley, code, serv, fclr} = '0;
      repeat (12) @(posedge ref_clk);
      @(negedge ref_clk) reset_n = 1'b1;
      H.rd(8'h0f, rd); chk("ch3_rst", 17'h0, {9'h0, rd});
      H.rd(8'h10, rd); chk("ramp_rst", 17'h0, {9'h0, rd});
      H.rd(8'h22, rd); chk("unmapped", 17'h0, {9'h0, rd});
      chk("rate_rst", 17'h2, {13'h0, rate[3]});
      $display("test reset done");
      for (i = 0; i < 16; i++) begin
         H.wr(8'h0f, {4'hf, i[3:0]});
         H.rd(8'h0f, rd); chk("ch3_rb", {13'h0, i[3:0]}, {9'h0, rd});
         chk("slot_ok", {16'h0, !i[2]}, {16'h0, sv});
         if (!i[2]) chk("slot", {15'h0, i[1:0]}, {15'h0, slot});
         chk("f_on", {16'h0, i[2] & i[1]}, {16'h0, fon});
         chk("f_off", {16'h0, i[2] & !i[1]}, {16'h0, foff});
         chk("dis", {16'h0, i[3]}, {16'h0, dis});
         @(negedge ref_clk) run = 1'b1;
         #1 chk("dis_run", 17'h0, {16'h0, dis});
         @(negedge ref_clk) run = 1'b0;
      end
      H.rd(8'h22, rd); chk("unmapped_rb", 17'h0, {9'h0, rd});
      $display("test ch3 enable done");
      for (i = 0; i < 5; i++) begin
         c = i * 8'h1b;
         H.wr(8'h10, c[7:0] | 8'hc0);
         H.rd(8'h10, rd); chk("ramp_rb", {11'h0, c[5:0]}, {9'h0, rd});
         for (int k = 0; k < 4; k++)
            chk("rate", c[k] ? (c[5] ? 17'ha : 17'h5) : 17'h2, {13'h0, rate[k]});
         chk("lle", {13'h0, c[4] ? c[3:0] : 4'h0}, {13'h0, lle});
      end
      H.wr(8'h10, 8'h00);
      $display("test ramp control done");
      for (i = 0; i < 4; i++) begin
         @(negedge ref_clk) {blp, icd} = i[1:0];
         #1 chk("pmode", {15'h0, blp ? {icd, 1'b1} : 2'b00}, {15'h0, pm});
      end
      @(negedge ref_clk) {blp, icd} = 2'b00;
      $display("test power mode done");
      lat(8'h18, 8'hc9, LAT_F);
      lat(8'h1f, 8'hc8, LAT_F);
      @(negedge ref_clk) step = 1'b1;
      lat(8'h10, 8'hff, LAT_S);
      $display("test ramp latency done");
      @(negedge ref_clk) {valley, serv} = 5'h15;
      repeat (4) @(posedge ref_clk);
      #1 chk("ost", 17'h5, {13'h0, ost});
      chk("ofl", 17'h5, {13'h0, ofl});
      @(negedge ref_clk) valley = 1'b0;
      repeat (4) @(posedge ref_clk);
      #1 chk("ost_gone", 17'h0, {13'h0, ost});
      chk("ofl_held", 17'h5, {13'h0, ofl});
      @(negedge ref_clk) fclr = 4'h1;
      @(negedge ref_clk) fclr = 4'h0;
      chk("ofl_clr", 17'h4, {13'h0, ofl});
      @(negedge ref_clk) valley = 1'b1;
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk) fclr = 4'h5;
      @(negedge ref_clk) fclr = 4'h0;
      chk("ofl_set_wins", 17'h5, {13'h0, ofl});
      $display("test overload done");
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
